// ### isrs_sensor.sv
// Sensor end: readout sequencer, delay taps, analog pipeline, ADC and parameter upload
//
// Contract
// - Line strobe one cycle, frame strobe three
// - Line strobe high suspends the sequencer
// - Strobes glitch-free, sampled on rising clock
// - Row blanking precedes every line readout
// - Pixel valid spans programmed pixel count
// - End-of-line one cycle after valid falls
// - End-of-frame after last programmed line
// - Line strobes spaced at equal intervals
// - Free-run feedback delayed two clocks minimum
// - Two outputs valid four cycles later
// - Single output valid five cycles later
// - Programmable delay shifts valid and markers
// - ADC samples falling edge, internal half-rate
// - ADC pipeline latency two ADC clocks
// - Parameter serial input shifts on rising
// - Sixteen-bit word, address first, MSB first
// - Four address bits, twelve data bits
// - Load strobe copies word into register
// - Global reset input is active high
// - Low nibble delays valid, high markers
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/10ps
module isrs_sensor
	import isrs_pkg::*;
(
	// System
	input  wire logic clk,
	input  wire logic arst_n,
	// Link to controller
	isrs_if.device    link
);
	// Sequencer state
	isrs_seq_t          state_reg,  state_next;
	logic [DATA_W-1:0]  pixCnt_reg, pixCnt_next;
	logic [DATA_W-1:0]  lineCnt_reg, lineCnt_next;
	logic [3:0]         blank_reg,  blank_next;
	logic               fall_reg,   fall_next;
	logic               last_reg,   last_next;
	// Parameter upload
	logic [WORD_W-1:0]  shift_reg,  shift_next;
	logic               pclkPrev_reg, loadPrev_reg;
	logic [DATA_W-1:0]  pixels_reg, pixels_next;
	logic [DATA_W-1:0]  lines_reg,  lines_next;
	logic [DATA_W-1:0]  delay_reg,  delay_next;
	logic [DATA_W-1:0]  amp_reg,    amp_next;
	logic [DATA_W-1:0]  adcCfg_reg, adcCfg_next;
	// Delay taps and outputs
	logic [DLY_MAX-1:0] pvSh_reg;
	// One stage longer: markers trail the fall of valid by a cycle
	logic [DLY_MAX:0]   eolSh_reg, eofSh_reg;
	logic               pv_reg, eol_reg, eof_reg;
	logic               pv_next, eol_next, eof_next;
	// Analog pipeline
	logic [PIX_W-1:0]   anaPipe_reg [ANA_DEP];
	logic [ANA_DEP-1:0] valPipe_reg;
	logic [PIX_W-1:0]   outA_reg, outB_reg, outA_next, outB_next;
	logic               outV_reg, outV_next;
	// ADC
	logic               adcInt_reg, adcPrev_reg, adcSel_reg;
	logic [PIX_W-1:0]   adcS0_reg, adcS1_reg, adcD_reg;
	logic               adcSrc, adcFall, reading, oneOut;
	logic [3:0]         tapPv, tapEv;

	assign reading = (state_reg == S_READ);
	assign oneOut  = amp_reg[AMP_ONE_OUT];
	assign tapPv   = isrs_tap(delay_reg[DLY_PV_LSB +: 4]);
	assign tapEv   = isrs_tap(delay_reg[DLY_EV_LSB +: 4]);

	// Sequencer next state
	always_comb begin
		state_next   = state_reg;
		pixCnt_next  = pixCnt_reg;
		lineCnt_next = lineCnt_reg;
		blank_next   = blank_reg;
		fall_next    = 1'b0;
		last_next    = 1'b0;
		if (link.frameStart) begin
			state_next   = S_IDLE;
			lineCnt_next = '0;
			pixCnt_next  = '0;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (link.lineClk) begin
						state_next = S_SUSP;
					end
				end
				S_SUSP: begin
					if (!link.lineClk) begin
						state_next = S_BLANK;
						blank_next = '0;
					end
				end
				S_BLANK: begin
					if (!link.lineClk) begin
						blank_next = 4'(blank_reg + 4'h1);
						if (blank_reg == BLANK_CYCLES - 4'h1) begin
							state_next  = S_READ;
							pixCnt_next = '0;
						end
					end
				end
				S_READ: begin
					if (!link.lineClk) begin
						pixCnt_next = 12'(pixCnt_reg + 12'h001);
						if (pixCnt_reg == 12'(pixels_reg - 12'h001)) begin
							state_next   = S_IDLE;
							fall_next    = 1'b1;
							lineCnt_next = 12'(lineCnt_reg + 12'h001);
							last_next    = (12'(lineCnt_reg + 12'h001) == lines_reg);
						end
					end
				end
				default: state_next = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg   <= S_IDLE;
			pixCnt_reg  <= '0;
			lineCnt_reg <= '0;
			blank_reg   <= '0;
			fall_reg    <= 1'b0;
			last_reg    <= 1'b0;
		end else if (link.sysReset) begin
			state_reg   <= S_IDLE;
			pixCnt_reg  <= '0;
			lineCnt_reg <= '0;
			blank_reg   <= '0;
			fall_reg    <= 1'b0;
			last_reg    <= 1'b0;
		end else begin
			state_reg   <= state_next;
			pixCnt_reg  <= pixCnt_next;
			lineCnt_reg <= lineCnt_next;
			blank_reg   <= blank_next;
			fall_reg    <= fall_next;
			last_reg    <= last_next;
		end
	end

	// Parameter upload next values
	always_comb begin
		shift_next  = shift_reg;
		pixels_next = pixels_reg;
		lines_next  = lines_reg;
		delay_next  = delay_reg;
		amp_next    = amp_reg;
		adcCfg_next = adcCfg_reg;
		// first bit ends up on top
		if (link.paramClk && !pclkPrev_reg) begin
			shift_next = {shift_reg[WORD_W-2:0], link.paramData};
		end
		if (link.regLoad && !loadPrev_reg) begin
			if (shift_reg[WORD_W-1 -: ADDR_W] == A_PIXELS) begin
				pixels_next = shift_reg[DATA_W-1:0];
			end else if (shift_reg[WORD_W-1 -: ADDR_W] == A_LINES) begin
				lines_next = shift_reg[DATA_W-1:0];
			end else if (shift_reg[WORD_W-1 -: ADDR_W] == A_DELAY) begin
				delay_next = shift_reg[DATA_W-1:0];
			end else if (shift_reg[WORD_W-1 -: ADDR_W] == A_AMP) begin
				amp_next = shift_reg[DATA_W-1:0];
			end else if (shift_reg[WORD_W-1 -: ADDR_W] == A_ADC) begin
				adcCfg_next = shift_reg[DATA_W-1:0];
			end
		end
	end

	// Parameters survive the sensor's global reset; only power-on clears them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_reg    <= '0;
			pclkPrev_reg <= 1'b0;
			loadPrev_reg <= 1'b0;
			pixels_reg   <= PIXELS_RST;
			lines_reg    <= LINES_RST;
			delay_reg    <= CFG_RST;
			amp_reg      <= CFG_RST;
			adcCfg_reg   <= CFG_RST;
		end else begin
			shift_reg    <= shift_next;
			pclkPrev_reg <= link.paramClk;
			loadPrev_reg <= link.regLoad;
			pixels_reg   <= pixels_next;
			lines_reg    <= lines_next;
			delay_reg    <= delay_next;
			amp_reg      <= amp_next;
			adcCfg_reg   <= adcCfg_next;
		end
	end

	// Delay tap selection and analog output mux
	always_comb begin
		pv_next  = (tapPv == 4'h0) ? reading  : pvSh_reg[4'(tapPv - 4'h1)];
		eol_next = eolSh_reg[tapEv];
		eof_next = eofSh_reg[tapEv];
		if (oneOut) begin
			outV_next = valPipe_reg[LAT_ONE_OUT-2];
			outA_next = anaPipe_reg[LAT_ONE_OUT-2];
			outB_next = '0;
		end else begin
			outV_next = valPipe_reg[LAT_TWO_OUT-2];
			outA_next = anaPipe_reg[LAT_TWO_OUT-2];
			outB_next = ~anaPipe_reg[LAT_TWO_OUT-2];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pvSh_reg    <= '0;
			eolSh_reg   <= '0;
			eofSh_reg   <= '0;
			pv_reg      <= 1'b0;
			eol_reg     <= 1'b0;
			eof_reg     <= 1'b0;
			valPipe_reg <= '0;
			outV_reg    <= 1'b0;
			outA_reg    <= '0;
			outB_reg    <= '0;
			for (int i = 0; i < ANA_DEP; i++) begin
				anaPipe_reg[i] <= '0;
			end
		end else if (link.sysReset) begin
			pvSh_reg    <= '0;
			eolSh_reg   <= '0;
			eofSh_reg   <= '0;
			pv_reg      <= 1'b0;
			eol_reg     <= 1'b0;
			eof_reg     <= 1'b0;
			valPipe_reg <= '0;
			outV_reg    <= 1'b0;
		end else begin
			pvSh_reg    <= {pvSh_reg[DLY_MAX-2:0], reading};
			eolSh_reg   <= {eolSh_reg[DLY_MAX-1:0], fall_reg};
			eofSh_reg   <= {eofSh_reg[DLY_MAX-1:0], fall_reg && last_reg};
			pv_reg      <= pv_next;
			eol_reg     <= eol_next;
			eof_reg     <= eof_next;
			valPipe_reg <= {valPipe_reg[ANA_DEP-2:0], reading};
			anaPipe_reg[0] <= pixCnt_reg[PIX_W-1:0];
			for (int i = 1; i < ANA_DEP; i++) begin
				anaPipe_reg[i] <= anaPipe_reg[i-1];
			end
			outV_reg    <= outV_next;
			outA_reg    <= outA_next;
			outB_reg    <= outB_next;
		end
	end

	assign adcSrc  = adcCfg_reg[ADC_EXT_CLK] ? link.adcClkExt : adcInt_reg;
	assign adcFall = adcPrev_reg && !adcSrc;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			adcInt_reg  <= 1'b0;
			adcPrev_reg <= 1'b0;
			adcSel_reg  <= 1'b0;
			adcS0_reg   <= '0;
			adcS1_reg   <= '0;
			adcD_reg    <= '0;
		end else begin
			adcInt_reg  <= !adcInt_reg;
			adcPrev_reg <= adcSrc;
			if (adcFall) begin
				// One converter serves both outputs by alternating the sampled output in two-output mode
				adcSel_reg <= oneOut ? 1'b0 : !adcSel_reg;
				adcS0_reg  <= adcSel_reg ? outB_reg : outA_reg;
				adcS1_reg  <= adcS0_reg;
				adcD_reg   <= adcS1_reg;
			end
		end
	end

	assign link.pixValid      = pv_reg;
	assign link.endOfLine     = eol_reg;
	assign link.endOfFrame    = eof_reg;
	assign link.analogOutputA = outA_reg;
	assign link.analogOutputB = outB_reg;
	assign link.analogValid   = outV_reg;
	assign link.adcData       = adcD_reg;
endmodule : isrs_sensor

// ### isrs_pkg.sv
// Shared constants and types of the sensor readout sequencer and its controller
package isrs_pkg;
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 12;
	localparam int WORD_W  = 16;
	localparam int PIX_W   = 10;
	localparam int DLY_MAX = 13;
	localparam int ANA_DEP = 4;
	localparam int BUS_W   = 32;

	// Sensor parameter register addresses
	localparam logic [3:0]  A_PIXELS = 4'h0;
	localparam logic [3:0]  A_LINES  = 4'h1;
	localparam logic [3:0]  A_DELAY  = 4'h2;
	localparam logic [3:0]  A_AMP    = 4'h3;
	localparam logic [3:0]  A_ADC    = 4'h4;
	localparam logic [11:0] PIXELS_RST = 12'h010;
	localparam logic [11:0] LINES_RST  = 12'h008;
	localparam logic [11:0] CFG_RST    = 12'h000;
	localparam int AMP_ONE_OUT = 0;
	localparam int ADC_EXT_CLK = 0;
	localparam int DLY_PV_LSB  = 0;
	localparam int DLY_EV_LSB  = 4;
	localparam logic [3:0] DLY_OFFSET = 4'h2;

	// Sequencer timing in system clock cycles
	localparam logic [3:0] BLANK_CYCLES = 4'h8;
	localparam int LAT_TWO_OUT = 4;
	localparam int LAT_ONE_OUT = 5;
	localparam logic [1:0] FRAME_MIN = 2'h3;
	localparam int FREE_DELAY = 2;

	// Controller register word addresses and fields
	localparam logic [3:0]  CR_CTRL   = 4'h0;
	localparam logic [3:0]  CR_PERIOD = 4'h1;
	localparam logic [3:0]  CR_PARAM  = 4'h2;
	localparam logic [3:0]  CR_STATUS = 4'h3;
	localparam int CTRL_RUN  = 0;
	localparam int CTRL_FREE = 1;
	localparam logic [15:0] PERIOD_RST = 16'h0040;

	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_SUSP  = 2'b01,
		S_BLANK = 2'b10,
		S_READ  = 2'b11
	} isrs_seq_t;

	typedef enum logic [1:0] {
		C_IDLE  = 2'b00,
		C_FRAME = 2'b01,
		C_LINES = 2'b10
	} isrs_ctl_t;

	typedef enum logic [1:0] {
		U_IDLE  = 2'b00,
		U_SETUP = 2'b01,
		U_CLOCK = 2'b10,
		U_LOAD  = 2'b11
	} isrs_up_t;

	// Delay setting nibble to added cycles: codes below three add nothing
	function automatic logic [3:0] isrs_tap(input logic [3:0] nib);
		isrs_tap = (nib > DLY_OFFSET) ? 4'(nib - DLY_OFFSET) : 4'h0;
	endfunction : isrs_tap
endpackage : isrs_pkg

// ### isrs_if.sv
// Pin-level link between the sensor sequencer and its camera controller
`timescale 1ns/10ps
interface isrs_if;
	import isrs_pkg::*;
	logic              sysReset;
	logic              lineClk;
	logic              frameStart;
	logic              paramClk;
	logic              paramData;
	logic              regLoad;
	logic              adcClkExt;
	logic              pixValid;
	logic              endOfLine;
	logic              endOfFrame;
	logic [PIX_W-1:0]  analogOutputA;
	logic [PIX_W-1:0]  analogOutputB;
	logic              analogValid;
	logic [PIX_W-1:0]  adcData;

	modport device (
		input  sysReset, lineClk, frameStart, paramClk, paramData, regLoad, adcClkExt,
		output pixValid, endOfLine, endOfFrame, analogOutputA, analogOutputB,
		output analogValid, adcData
	);
	modport ctrl (
		output sysReset, lineClk, frameStart, paramClk, paramData, regLoad, adcClkExt,
		input  pixValid, endOfLine, endOfFrame, analogOutputA, analogOutputB,
		input  analogValid, adcData
	);
endinterface : isrs_if

// ### isrs_ctrl.sv
// Controller end: frame and line strobes, serial parameter upload, register port
`timescale 1ns/10ps
module isrs_ctrl
	import isrs_pkg::*;
(
	// System
	input  wire logic              clk,
	input  wire logic              arst_n,
	// Register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [BUS_W-1:0]  wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [BUS_W-1:0]  rdata,
	// Link to sensor
	isrs_if.ctrl                   link
);
	isrs_ctl_t         state_reg,  state_next;
	isrs_up_t          up_reg,     up_next;
	logic [1:0]        ctrl_reg,   ctrl_next;
	logic [15:0]       period_reg, period_next;
	logic [15:0]       cnt_reg,    cnt_next;
	logic [1:0]        fsCnt_reg,  fsCnt_next;
	logic [15:0]       frames_reg, frames_next;
	logic [WORD_W-1:0] word_reg,   word_next;
	logic [3:0]        bit_reg,    bit_next;
	logic [FREE_DELAY-1:0] eolDly_reg, eofDly_reg;
	logic              fs_reg, fs_next, lc_reg, lc_next;
	logic              pc_reg, pc_next, pd_reg, pd_next, rl_reg, rl_next;
	logic [BUS_W-1:0]  rdata_reg,  rdata_next;

	always_comb begin
		state_next  = state_reg;
		up_next     = up_reg;
		ctrl_next   = ctrl_reg;
		period_next = period_reg;
		cnt_next    = cnt_reg;
		fsCnt_next  = fsCnt_reg;
		frames_next = frames_reg;
		word_next   = word_reg;
		bit_next    = bit_reg;
		fs_next     = 1'b0;
		lc_next     = 1'b0;
		pc_next     = 1'b0;
		pd_next     = pd_reg;
		rl_next     = 1'b0;
		rdata_next  = '0;
		if (wr && addr == CR_CTRL) begin
			ctrl_next = wdata[1:0];
		end else if (wr && addr == CR_PERIOD) begin
			period_next = wdata[15:0];
		end
		if (rd && addr == CR_CTRL) begin
			rdata_next = {30'h0, ctrl_reg};
		end else if (rd && addr == CR_PERIOD) begin
			rdata_next = {16'h0, period_reg};
		end else if (rd && addr == CR_STATUS) begin
			rdata_next = {frames_reg, 14'h0, (state_reg != C_IDLE), (up_reg != U_IDLE)};
		end
		// Frame and line strobe generation
		case (state_reg)
			C_IDLE: begin
				if (ctrl_reg[CTRL_RUN]) begin
					state_next = C_FRAME;
					fsCnt_next = '0;
				end
			end
			C_FRAME: begin
				fs_next    = 1'b1;
				fsCnt_next = 2'(fsCnt_reg + 2'h1);
				// Strobe stays up through the last count, giving three full cycles
				if (fsCnt_reg == FRAME_MIN - 2'h1) begin
					state_next  = C_LINES;
					cnt_next    = '0;
					frames_next = 16'(frames_reg + 16'h0001);
				end
			end
			C_LINES: begin
				cnt_next = 16'(cnt_reg + 16'h0001);
				// free-run via delayed markers
				// Free run has no marker before its first line, so the period starts it;
				// the period must then exceed one line or a line is strobed twice
				if (cnt_reg == period_reg || (ctrl_reg[CTRL_FREE] && eolDly_reg[FREE_DELAY-1])) begin
					lc_next  = 1'b1;
					cnt_next = '0;
				end
				if (!ctrl_reg[CTRL_RUN]) begin
					state_next = C_IDLE;
				end else if (eofDly_reg[FREE_DELAY-1]) begin
					state_next = C_FRAME;
					fsCnt_next = '0;
				end
			end
			default: state_next = C_IDLE;
		endcase
		// Serial upload: data set with clock low, then clock high, then load
		case (up_reg)
			U_IDLE: begin
				if (wr && addr == CR_PARAM) begin
					word_next = wdata[WORD_W-1:0];
					bit_next  = '0;
					up_next   = U_SETUP;
				end
			end
			U_SETUP: begin
				pd_next = word_reg[WORD_W-1];
				up_next = U_CLOCK;
			end
			U_CLOCK: begin
				pc_next   = 1'b1;
				word_next = {word_reg[WORD_W-2:0], 1'b0};
				bit_next  = 4'(bit_reg + 4'h1);
				up_next   = (bit_reg == 4'hF) ? U_LOAD : U_SETUP;
			end
			U_LOAD: begin
				rl_next = 1'b1;
				up_next = U_IDLE;
			end
			default: up_next = U_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg  <= C_IDLE;
			up_reg     <= U_IDLE;
			ctrl_reg   <= '0;
			period_reg <= PERIOD_RST;
			cnt_reg    <= '0;
			fsCnt_reg  <= '0;
			frames_reg <= '0;
			word_reg   <= '0;
			bit_reg    <= '0;
			eolDly_reg <= '0;
			eofDly_reg <= '0;
			fs_reg     <= 1'b0;
			lc_reg     <= 1'b0;
			pc_reg     <= 1'b0;
			pd_reg     <= 1'b0;
			rl_reg     <= 1'b0;
			rdata_reg  <= '0;
		end else begin
			state_reg  <= state_next;
			up_reg     <= up_next;
			ctrl_reg   <= ctrl_next;
			period_reg <= period_next;
			cnt_reg    <= cnt_next;
			fsCnt_reg  <= fsCnt_next;
			frames_reg <= frames_next;
			word_reg   <= word_next;
			bit_reg    <= bit_next;
			eolDly_reg <= {eolDly_reg[FREE_DELAY-2:0], link.endOfLine};
			eofDly_reg <= {eofDly_reg[FREE_DELAY-2:0], link.endOfFrame};
			fs_reg     <= fs_next;
			lc_reg     <= lc_next;
			pc_reg     <= pc_next;
			pd_reg     <= pd_next;
			rl_reg     <= rl_next;
			rdata_reg  <= rdata_next;
		end
	end

	assign link.frameStart = fs_reg;
	assign link.lineClk    = lc_reg;
	assign link.paramClk   = pc_reg;
	assign link.paramData  = pd_reg;
	assign link.regLoad    = rl_reg;
	assign link.sysReset   = 1'b0;
	assign link.adcClkExt  = 1'b0;
	assign rdata           = rdata_reg;
endmodule : isrs_ctrl

// ### isrs_asserts.sv
// Concurrent checks on the link between sensor and controller
`timescale 1ns/10ps
module isrs_asserts
	import isrs_pkg::*;
(
	// System
	input wire logic             clk,
	input wire logic             arst_n,
	// Link strobes
	input wire logic             sysReset,
	input wire logic             lineClk,
	input wire logic             frameStart,
	input wire logic             paramClk,
	input wire logic             paramData,
	input wire logic             regLoad,
	// Link results
	input wire logic             pixValid,
	input wire logic             endOfLine,
	input wire logic             endOfFrame,
	input wire logic [PIX_W-1:0] adcData
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!arst_n || sysReset);

	line_strobe_a: assert property ($rose(lineClk) |=> !lineClk)
		else $error("line strobe not one cycle");
	frame_strobe_a: assert property ($rose(frameStart) |-> frameStart [*3])
		else $error("frame strobe shorter than three cycles");
	suspend_hold_a: assert property (lineClk && !pixValid |=> !pixValid)
		else $error("readout advanced under line strobe");
	row_blank_a: assert property ($fell(lineClk) |-> !pixValid [*8])
		else $error("pixel valid inside row blanking");
	eol_after_a: assert property ($fell(pixValid) |=> endOfLine)
		else $error("end of line missing after valid");
	eol_cause_a: assert property ($rose(endOfLine) |-> $past(pixValid, 2) && !$past(pixValid))
		else $error("end of line without valid falling");
	eof_marker_a: assert property (endOfFrame |-> endOfLine ##1 !endOfFrame)
		else $error("end of frame not a pulse with end of line");
	frame_gap_a: assert property (endOfFrame |-> !frameStart ##1 !frameStart)
		else $error("frame restart closer than two cycles");
	serial_clock_a: assert property (paramClk |-> $stable(paramData) ##1 !paramClk)
		else $error("serial data moved at its clock");
	load_pulse_a: assert property (regLoad |=> !regLoad && !paramClk)
		else $error("load strobe not a lone pulse");
	adc_rate_a: assert property (!$stable(adcData) |=> $stable(adcData))
		else $error("converter output faster than half rate");
endmodule : isrs_asserts

// ### isrs_test.sv
// Self-checking bench for the sensor sequencer and its controller
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module isrs_test
	import isrs_pkg::*;
;
	logic              clk;
	logic              arst_n;
	logic [ADDR_W-1:0] addr;
	logic [BUS_W-1:0]  wdata;
	logic              wr;
	logic              rd;
	logic [BUS_W-1:0]  rdata;
	int                n_mismatch;
	int                checks_done;
	int                nEof;
	logic [31:0]       qRd[$], qLen[$], qLns[$], qDly[$], qLat[$], qAna[$];
	logic [31:0]       e, pvLen, nLns, dly;
	logic              rdPrev, lcPrev, pvPrev, avPrev;

	isrs_if isrs_if_inst ();
	isrs_sensor isrs_sensor_inst (.clk(clk), .arst_n(arst_n), .link(isrs_if_inst.device));
	isrs_ctrl isrs_ctrl_inst (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .link(isrs_if_inst.ctrl));
	isrs_asserts isrs_asserts_inst (.clk(clk), .arst_n(arst_n),
		.sysReset(isrs_if_inst.sysReset), .lineClk(isrs_if_inst.lineClk),
		.frameStart(isrs_if_inst.frameStart), .paramClk(isrs_if_inst.paramClk),
		.paramData(isrs_if_inst.paramData), .regLoad(isrs_if_inst.regLoad),
		.pixValid(isrs_if_inst.pixValid), .endOfLine(isrs_if_inst.endOfLine),
		.endOfFrame(isrs_if_inst.endOfFrame), .adcData(isrs_if_inst.adcData));

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	task automatic wrReg(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrReg

	task automatic rdReg(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] x);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		qRd.push_back(x);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rdReg

	task automatic upParam(input logic [3:0] a, input logic [11:0] d, input bit refuse);
		int k = 0;
		wrReg(CR_PARAM, {16'h0000, a, d});
		if (refuse) begin
			// Busy upload: a second word must be dropped, else frames shrink to one line
			rdReg(CR_STATUS, 32'h0000_0001);
			wrReg(CR_PARAM, {16'h0000, A_LINES, 12'h001});
		end
		while (isrs_if_inst.regLoad !== 1'b1 && k < 200) begin
			@(posedge clk);
			k++;
		end
		if (k >= 200) begin
			n_mismatch++;
			summarize();
		end
		repeat (2) @(posedge clk);
	endtask : upParam

	task automatic waitEof(input int n);
		int k = 0;
		nEof = 0;
		while (nEof < n && k < 5000) begin
			@(posedge clk);
			k++;
		end
		if (nEof < n) begin
			n_mismatch++;
			summarize();
		end
	endtask : waitEof

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Watcher: takes the oldest note whenever a result shows on the outputs
	always @(posedge clk) begin
		if (!arst_n) begin
			rdPrev = 1'b0;
			lcPrev = 1'b0;
			pvPrev = 1'b0;
			avPrev = 1'b0;
			pvLen  = '0;
			nLns   = '0;
			dly    = '0;
		end else begin
			if (rdPrev) begin
				e = qRd.pop_front();
				`CHK(rdata, e)
			end
			dly = (lcPrev && !isrs_if_inst.lineClk) ? 32'h0 : dly + 32'h1;
			if (isrs_if_inst.pixValid && !pvPrev && qDly.size() > 0) begin
				e = qDly.pop_front();
				`CHK(dly, e)
			end
			if (isrs_if_inst.analogValid && !avPrev && qLat.size() > 0) begin
				e = qLat.pop_front();
				`CHK(dly, e)
				if (qAna.size() > 0) begin
					e = qAna.pop_front();
					`CHK({isrs_if_inst.analogOutputA, isrs_if_inst.analogOutputB}, e)
				end
			end
			if (isrs_if_inst.pixValid) pvLen = pvLen + 32'h1;
			if (!isrs_if_inst.pixValid && pvPrev) begin
				if (qLen.size() > 0) begin
					e = qLen.pop_front();
					`CHK(pvLen, e)
				end
				pvLen = '0;
			end
			if (isrs_if_inst.frameStart) nLns = '0;
			if (isrs_if_inst.endOfFrame) begin
				nEof++;
				if (qLns.size() > 0) begin
					e = qLns.pop_front();
					`CHK(nLns + 32'h1, e)
				end
			end
			if (isrs_if_inst.endOfLine) nLns = nLns + 32'h1;
			rdPrev = rd;
			lcPrev = isrs_if_inst.lineClk;
			pvPrev = isrs_if_inst.pixValid;
			avPrev = isrs_if_inst.analogValid;
		end
	end

	initial begin
		logic [11:0] pix, lns, nib;
		int          tap, lat;
		arst_n      = 1'b0;
		addr        = '0;
		wdata       = '0;
		wr          = 1'b0;
		rd          = 1'b0;
		n_mismatch  = 0;
		checks_done = 0;
		nEof        = 0;
		void'($urandom(32'h6948ed1c));
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		// Reset values, unmapped word, read-only status
		rdReg(CR_CTRL, 32'h0000_0000);
		rdReg(CR_PERIOD, {16'h0000, PERIOD_RST});
		rdReg(4'h9, 32'h0000_0000);
		wrReg(CR_STATUS, 32'hFFFF_FFFF);
		rdReg(CR_STATUS, 32'h0000_0000);
		wrReg(CR_PERIOD, 32'h0000_0050);
		rdReg(CR_PERIOD, 32'h0000_0050);
		// Modes: timed two-output, timed one-output, then both in free run
		for (int i = 0; i < 4; i++) begin
			pix = 12'($urandom_range(20, 2));
			lns = 12'($urandom_range(4, 2));
			nib = (i == 0) ? 12'h002 : (i == 1) ? 12'h003 : 12'($urandom_range(15, 0));
			tap = (nib > 12'h002) ? int'(nib) - 2 : 0;
			lat = (i % 2 == 1) ? LAT_ONE_OUT : LAT_TWO_OUT;
			upParam(A_PIXELS, pix, 1'b0);
			upParam(A_LINES, lns, 1'b0);
			upParam(A_DELAY, {4'h0, nib[3:0], nib[3:0]}, 1'b0);
			upParam(A_AMP, 12'(i % 2), i == 0);
			for (int j = 0; j < 2 * int'(lns); j++) begin
				qLen.push_back(32'(pix));
				qDly.push_back(32'(10 + tap));
				qLat.push_back(32'(9 + lat));
				// First pixel is zero; the second output carries its inverse or rests
				qAna.push_back((i % 2 == 1) ? 32'h0000_0000 : 32'h0000_03FF);
			end
			qLns.push_back(32'(lns));
			qLns.push_back(32'(lns));
			wrReg(CR_CTRL, (i >= 2) ? 32'h0000_0003 : 32'h0000_0001);
			waitEof(2);
			wrReg(CR_CTRL, 32'h0000_0000);
			repeat (120) @(posedge clk);
		end
		summarize();
	end
endmodule : isrs_test
